// [rtl/rpb_top.sv]
//
// Function
// [R1] Bit 0 low parks arbiter on last master; high parks on own port; resets 0.
// [R2] Bit 1 low enables dynamic read prefetch control; high disables; resets 0.
// [R3] Bit 2 low enables completion data prediction; high disables; resets 0.
// [R4] Read Multiple depth field 5:4: 00 one line, others full; resets 10.
// [R5] Read Multiple 01 keeps leftovers after bridge disconnect, 11 after any end.
// [R6] Read Multiple and Read Line fields ignored in PCI-X mode.
// [R7] Read Line depth field 7:6: 00 one line, others full; resets 00.
// [R8] Read Line 01 keeps leftovers after bridge disconnect, 11 after any end.
// [R9] Memory Read field 9:8: 00 line, 01 reserved, 10 full, 11 first dword.
// [R10] Bit 10 low: retry a master repeating with a changed command.
// [R11] Bit 10 high: command may change; complete when address and enables match.
// [R12] Field 14:12 sets upstream read byte limit; 000/011/111 mean 512.
// [R13] Byte limit applies only to reads whose mode selects full prefetch.
// [R14] Discard timer counts 2^15 or 2^10 clocks per master-timeout select.
// [R15] New settings reach only transactions accepted after the write.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module rpb_top #(
  parameter int DISC_LONG_CYC = 2 ** rpb_pkg::DISC_LONG_EXP,
  parameter int DISC_SHORT_CYC = 2 ** rpb_pkg::DISC_SHORT_EXP,
  parameter int BUF_DEPTH = 2
)(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [rpb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic req_valid,
  input wire rpb_pkg::rpb_req_s req,
  output logic req_ready,
  output logic dec_valid,
  output rpb_pkg::rpb_dec_s dec,
  input wire logic dec_ready,
  input wire logic pcix_mode,
  input wire logic mto_short,
  input wire logic term_valid,
  input wire logic term_by_bridge,
  output logic park_self,
  output logic dyn_prefetch_off,
  output logic predict_off,
  output logic retain_held,
  output logic discard_pulse
);
  import rpb_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  rpb_state_e state;
  logic pend_valid;
  logic [31:0] pend_addr;
  logic [3:0] pend_be;
  rpb_cmd_e pend_cmd;
  rpb_dec_s pend_dec;
  rpb_keep_e act_keep;
  logic [15:0] hold_lim;
  logic tmr_exp;
  logic [$bits(rpb_dec_s)-1:0] buf_out;
  rpb_dec_s next_dec;
  rpb_state_e next_state;

  localparam logic [15:0] LIM_LONG = 16'(DISC_LONG_CYC);
  localparam logic [15:0] LIM_SHORT = 16'(DISC_SHORT_CYC);

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  wire rd_ctrl = reg_rd && (reg_addr == OFS_CTRL);
  wire rd_stat = reg_rd && (reg_addr == OFS_STAT);
  wire [31:0] stat_word = {27'h000_0000, hold_lim == LIM_SHORT, pend_valid,
                           state == ST_HELD, state == ST_ACTIVE, state == ST_IDLE};
  wire [31:0] next_rdata = rd_ctrl ? ctrl : (rd_stat ? stat_word : 32'h0000_0000);
  wire [31:0] next_ctrl = (ctrl & ~CTRL_WMASK) | (reg_wdata & CTRL_WMASK);

  // ---------------------------------------------------------------
  // Request classification
  // ---------------------------------------------------------------
  wire acc = req_valid && req_ready;
  wire special = ctrl[CTRL_SPEC];
  wire [1:0] f_mrm = ctrl[CTRL_MRM_LO +: 2];
  wire [1:0] f_mrl = ctrl[CTRL_MRL_LO +: 2];
  wire [1:0] f_mr = ctrl[CTRL_MR_LO +: 2];
  wire [2:0] f_mbc = ctrl[CTRL_MBC_LO +: 3];
  wire burst_cmd = req.cmd != RPB_CMD_MR;
  wire [1:0] fsel = (req.cmd == RPB_CMD_MRM) ? f_mrm : ((req.cmd == RPB_CMD_MRL) ? f_mrl : f_mr);
  // PCI-X carries its own byte counts, so burst fields drop out
  wire pcix_ovr = pcix_mode && burst_cmd; // [R6]

  // Depth of a fresh request; Memory Read code 01 falls back to one line
  wire rpb_depth_e new_depth = !req.pf ? DEP_NONE :
                               pcix_ovr ? DEP_FULL : // [R6]
                               burst_cmd ? ((fsel == PF_LINE) ? DEP_LINE : DEP_FULL) : // [R4] [R7]
                               (fsel == MR_FIRST_DW) ? DEP_DW1 : // [R9]
                               (fsel == PF_FULL) ? DEP_FULL : DEP_LINE; // [R9]
  wire rpb_keep_e new_keep = (!req.pf || pcix_ovr || !burst_cmd) ? KEEP_NONE :
                             (fsel == PF_KEEP_DISC) ? KEEP_DISC : // [R5] [R8]
                             (fsel == PF_KEEP_ANY) ? KEEP_ANY : KEEP_NONE; // [R5] [R8]
  wire [12:0] new_bytes = (f_mbc == 3'h1) ? BC_128 : // [R12]
                          (f_mbc == 3'h2) ? BC_256 :
                          (f_mbc == 3'h4) ? BC_1024 :
                          (f_mbc == 3'h5) ? BC_2048 :
                          (f_mbc == 3'h6) ? BC_4096 : BC_512;

  // Only one delayed read is tracked; any other request is retried
  wire same = pend_valid && (req.addr == pend_addr) && (req.be == pend_be);
  wire cmd_chg = same && (req.cmd != pend_cmd);
  wire rpb_act_e act = !same ? (pend_valid ? ACT_RETRY : ACT_QUEUE) :
                       (cmd_chg && !special) ? ACT_RETRY : // [R10]
                       ACT_DONE; // [R11]

  always_comb
  begin
    if (same)
      next_dec = pend_dec; // [R15]
    else
    begin
      next_dec.depth = new_depth;
      next_dec.keep = new_keep;
      next_dec.limit_en = new_depth == DEP_FULL; // [R13]
      next_dec.max_bytes = new_bytes; // [R12]
    end
    next_dec.act = act;
  end

  // ---------------------------------------------------------------
  // Transfer and retention sequencing
  // ---------------------------------------------------------------
  wire done_acc = acc && (act == ACT_DONE);
  wire keep_now = (act_keep == KEEP_ANY) || ((act_keep == KEEP_DISC) && term_by_bridge); // [R5] [R8]
  wire enter_held = (state == ST_ACTIVE) && term_valid && keep_now && !done_acc;
  wire leave_held = (state == ST_HELD) && done_acc;
  wire [15:0] next_lim = mto_short ? LIM_SHORT : LIM_LONG; // [R14]

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (done_acc)
          next_state = ST_ACTIVE;
      ST_ACTIVE:
        if (done_acc)
          next_state = ST_ACTIVE;
        else if (term_valid)
          next_state = keep_now ? ST_HELD : ST_IDLE;
      ST_HELD:
        // A new completion replaces whatever was left over
        if (done_acc)
          next_state = ST_ACTIVE;
        else if (tmr_exp)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ctrl <= CTRL_RST;
    else if (wr_ctrl)
      ctrl <= next_ctrl;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= next_rdata;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      park_self <= 1'b0;
      dyn_prefetch_off <= 1'b0;
      predict_off <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      park_self <= reg_wdata[CTRL_PARK]; // [R1]
      dyn_prefetch_off <= reg_wdata[CTRL_DYN_OFF]; // [R2]
      predict_off <= reg_wdata[CTRL_PRED_OFF]; // [R3]
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_valid <= 1'b0;
      pend_addr <= 32'h0000_0000;
      pend_be <= 4'h0;
      pend_cmd <= RPB_CMD_MR;
      pend_dec <= '0;
    end
    else if (acc && (act == ACT_QUEUE))
    begin
      // Settings are frozen here for the life of the transaction
      pend_valid <= 1'b1;
      pend_addr <= req.addr;
      pend_be <= req.be;
      pend_cmd <= req.cmd;
      pend_dec <= next_dec; // [R15]
    end
    else if (done_acc)
      pend_valid <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      act_keep <= KEEP_NONE;
      hold_lim <= LIM_LONG;
      retain_held <= 1'b0;
      discard_pulse <= 1'b0;
    end
    else
    begin
      state <= next_state;
      retain_held <= next_state == ST_HELD;
      discard_pulse <= (state == ST_HELD) && tmr_exp && !done_acc;
      if (done_acc)
        act_keep <= pend_dec.keep; // [R15]
      if (enter_held)
        hold_lim <= next_lim; // [R14]
    end
  end

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  rpb_disc_tmr u_tmr (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(enter_held),
    .stop(leave_held),
    .limit(next_lim),
    .expire(tmr_exp)
  );

  // Stall on dec_ready reaches the request side through req_ready
  rpb_buf #(.W($bits(rpb_dec_s)), .DEPTH(BUF_DEPTH)) u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(req_valid),
    .in_data(next_dec),
    .in_ready(req_ready),
    .out_valid(dec_valid),
    .out_data(buf_out),
    .out_ready(dec_ready)
  );

  assign dec = rpb_dec_s'(buf_out);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  logic [15:0] held_cycles;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      held_cycles <= 16'h0000;
    else if (state != ST_HELD)
      held_cycles <= 16'h0000;
    else
      held_cycles <= held_cycles + 16'h0001;
  end

  AST_PARK_FOLLOWS_WRITE: assert property (wr_ctrl |=> park_self == $past(reg_wdata[CTRL_PARK])) // [R1]
    else $error("park select not taken from write");
  AST_DYN_FOLLOWS_WRITE: assert property (wr_ctrl |=> dyn_prefetch_off == ctrl[CTRL_DYN_OFF]) // [R2]
    else $error("dynamic prefetch control mismatch");
  AST_PRED_FOLLOWS_WRITE: assert property (wr_ctrl |=> predict_off == ctrl[CTRL_PRED_OFF]) // [R3]
    else $error("prediction control mismatch");
  AST_MRM_LINE: assert property (acc && act == ACT_QUEUE && req.pf && !pcix_mode && req.cmd == RPB_CMD_MRM
    && f_mrm == PF_LINE |=> pend_dec.depth == DEP_LINE) // [R4]
    else $error("read multiple one-line depth wrong");
  AST_KEEP_DISC_ONLY: assert property (state == ST_ACTIVE && term_valid && !term_by_bridge
    && act_keep == KEEP_DISC && !done_acc |=> state == ST_IDLE && !retain_held) // [R5]
    else $error("leftover kept after master termination");
  AST_PCIX_IGNORES: assert property (acc && act == ACT_QUEUE && req.pf && pcix_mode && burst_cmd
    |=> pend_dec.depth == DEP_FULL && pend_dec.keep == KEEP_NONE) // [R6]
    else $error("burst field used in PCI-X mode");
  AST_MRL_KEEP_ANY: assert property (state == ST_ACTIVE && term_valid && act_keep == KEEP_ANY
    && !done_acc |=> retain_held [*2]) // [R8]
    else $error("leftover not kept after any termination");
  AST_MRL_RESET: assert property ($rose(resetn) |-> f_mrl == PF_LINE && f_mrm == PF_FULL) // [R7]
    else $error("prefetch field reset value wrong");
  AST_MR_FIRST_DW: assert property (acc && act == ACT_QUEUE && req.pf && req.cmd == RPB_CMD_MR
    && f_mr == MR_FIRST_DW |=> pend_dec.depth == DEP_DW1 && !pend_dec.limit_en) // [R9]
    else $error("first dword disconnect not chosen");
  AST_RETRY_ON_CHANGE: assert property (acc && cmd_chg && !special |=> pend_valid
    && $stable(pend_addr)) // [R10]
    else $error("changed command not retried");
  AST_SPECIAL_DONE: assert property (acc && cmd_chg && special |=> !pend_valid
    && state == ST_ACTIVE) // [R11]
    else $error("special delayed read not completed");
  AST_BYTES_128: assert property (acc && act == ACT_QUEUE && f_mbc == 3'h1 |=> pend_dec.max_bytes == BC_128) // [R12]
    else $error("byte count code not decoded");
  AST_LIMIT_FULL_ONLY: assert property (acc && act == ACT_QUEUE // [R13]
    |=> pend_dec.limit_en == (pend_dec.depth == DEP_FULL))
    else $error("byte limit on non full prefetch");
  AST_DISCARD_TIME: assert property (state == ST_HELD && tmr_exp |-> held_cycles == hold_lim) // [R14]
    else $error("discard timer length wrong");
  AST_DONE_USES_SNAPSHOT: assert property (done_acc |=> act_keep == $past(pend_dec.keep)) // [R15]
    else $error("completion did not use frozen settings");

  COV_QUEUE_THEN_DONE: cover property (acc && act == ACT_QUEUE ##[1:20] done_acc);
  COV_RETRY_CHANGE: cover property (acc && cmd_chg && !special);
  COV_HELD_DISCARD: cover property (enter_held ##[1:1000] discard_pulse);
  COV_STALL_FULL: cover property (req_valid && !req_ready);
endmodule

// [pkg/rpb_pkg.sv]
package rpb_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h40;
  localparam logic [7:0] OFS_STAT = 8'h44;

  localparam int CTRL_PARK = 0;
  localparam int CTRL_DYN_OFF = 1;
  localparam int CTRL_PRED_OFF = 2;
  localparam int CTRL_MRM_LO = 4;
  localparam int CTRL_MRL_LO = 6;
  localparam int CTRL_MR_LO = 8;
  localparam int CTRL_SPEC = 10;
  localparam int CTRL_MBC_LO = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0020;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_77F7;

  localparam int STAT_IDLE = 0;
  localparam int STAT_ACTIVE = 1;
  localparam int STAT_HELD = 2;
  localparam int STAT_PEND = 3;
  localparam int STAT_HOLD_SHORT = 4;

  // ---------------------------------------------------------------
  // Field codes
  // ---------------------------------------------------------------
  localparam logic [1:0] PF_LINE = 2'h0;
  localparam logic [1:0] PF_KEEP_DISC = 2'h1;
  localparam logic [1:0] PF_FULL = 2'h2;
  localparam logic [1:0] PF_KEEP_ANY = 2'h3;
  localparam logic [1:0] MR_FIRST_DW = 2'h3;

  localparam logic [12:0] BC_128 = 13'h0080;
  localparam logic [12:0] BC_256 = 13'h0100;
  localparam logic [12:0] BC_512 = 13'h0200;
  localparam logic [12:0] BC_1024 = 13'h0400;
  localparam logic [12:0] BC_2048 = 13'h0800;
  localparam logic [12:0] BC_4096 = 13'h1000;

  // Discard timer lengths in PCI clocks, as powers of two
  localparam int DISC_LONG_EXP = 15;
  localparam int DISC_SHORT_EXP = 10;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RPB_CMD_MR = 2'h0, RPB_CMD_MRL = 2'h1, RPB_CMD_MRM = 2'h2} rpb_cmd_e;
  typedef enum logic [1:0] {DEP_NONE = 2'h0, DEP_LINE = 2'h1, DEP_FULL = 2'h2, DEP_DW1 = 2'h3} rpb_depth_e;
  typedef enum logic [1:0] {KEEP_NONE = 2'h0, KEEP_DISC = 2'h1, KEEP_ANY = 2'h2} rpb_keep_e;
  typedef enum logic [1:0] {ACT_QUEUE = 2'h0, ACT_RETRY = 2'h1, ACT_DONE = 2'h2} rpb_act_e;
  typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_ACTIVE = 3'h2, ST_HELD = 3'h4} rpb_state_e;

  typedef struct packed {
    rpb_cmd_e cmd;
    logic [31:0] addr;
    logic [3:0] be;
    logic pf;
  } rpb_req_s;

  typedef struct packed {
    rpb_act_e act;
    rpb_depth_e depth;
    rpb_keep_e keep;
    logic limit_en;
    logic [12:0] max_bytes;
  } rpb_dec_s;

endpackage

// [rtl/rpb_buf.sv]
`timescale 1ns/10ps
module rpb_buf #(
  parameter int W = 20,
  parameter int DEPTH = 2
)(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  // Shifting queue: the head is always entry 0, so the output is a flop
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] next_mem [DEPTH];
  logic [DEPTH-1:0] vld;
  logic [DEPTH-1:0] next_vld;
  logic [DEPTH-1:0] sv;
  // Ready kept in a flop so the port needs no gate after the register
  logic rdy;
  wire pop = vld[0] && out_ready;
  wire push = in_valid && in_ready;

  assign in_ready = rdy;
  assign out_valid = vld[0];
  assign out_data = mem[0];

  always_comb
  begin
    logic prev;
    prev = 1'b1;
    for (int i = 0; i < DEPTH; i++)
    begin
      sv[i] = pop ? ((i < DEPTH - 1) ? vld[(i + 1) % DEPTH] : 1'b0) : vld[i];
      next_mem[i] = pop ? ((i < DEPTH - 1) ? mem[(i + 1) % DEPTH] : mem[i]) : mem[i];
    end
    next_vld = sv;
    for (int i = 0; i < DEPTH; i++)
    begin
      if (push && !sv[i] && prev)
      begin
        next_vld[i] = 1'b1;
        next_mem[i] = in_data;
      end
      prev = sv[i];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vld <= '0;
      rdy <= 1'b1;
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
    end
    else
    begin
      vld <= next_vld;
      rdy <= !next_vld[DEPTH-1];
      mem <= next_mem;
    end
  end
endmodule

// [rtl/rpb_disc_tmr.sv]
`timescale 1ns/10ps
module rpb_disc_tmr (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic stop,
  input wire logic [15:0] limit,
  output logic expire
);
  logic [15:0] cnt;
  logic [15:0] lim;
  logic run;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 16'h0000;
      lim <= 16'h0000;
      run <= 1'b0;
      expire <= 1'b0;
    end
    else
    begin
      expire <= 1'b0;
      if (start)
      begin
        cnt <= 16'h0000;
        lim <= limit;
        run <= 1'b1;
      end
      else if (stop)
        run <= 1'b0;
      else if (run)
      begin
        if (cnt == lim - 16'h0001)
        begin
          run <= 1'b0;
          expire <= 1'b1;
        end
        else
          cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule

// [dv/rpb_pci_master.sv]
`timescale 1ns/10ps
module rpb_pci_master (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic stall,
  output logic req_valid,
  output rpb_pkg::rpb_req_s req,
  input wire logic req_ready,
  input wire logic dec_valid,
  output logic dec_ready
);
  import rpb_pkg::*;

  // ---------------------------------------------------------------
  // Request side
  // ---------------------------------------------------------------
  initial
  begin
    req_valid = 1'h0;
    req = '0;
  end

  // Held until taken; a released bus shows the inverse, not stale data
  task automatic send(input rpb_req_s r, input bit last);
    req_valid <= 1'h1;
    req <= r;
    do @(posedge ref_clk); while (req_ready !== 1'h1);
    if (last)
    begin
      req_valid <= 1'h0;
      req <= rpb_req_s'(~r);
    end
  endtask

  // ---------------------------------------------------------------
  // Decision side: slow at random, stops dead on stall
  // ---------------------------------------------------------------
  always @(posedge ref_clk or negedge resetn)
    if (!resetn)
      dec_ready <= 1'h0;
    else
      dec_ready <= !stall && ($urandom_range(3) != 0);
endmodule

// [dv/test_pci_read_prefetch_buffer_control.sv]
`timescale 1ns/10ps
module test_pci_read_prefetch_buffer_control;
  import rpb_pkg::*;
  localparam int LONG_C = 16;
  localparam int SHORT_C = 8;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic req_valid, req_ready, dec_valid, dec_ready;
  rpb_req_s req;
  rpb_dec_s dec;
  logic pcix_mode = 1'h0;
  logic mto_short = 1'h0;
  logic term_valid = 1'h0;
  logic term_by_bridge = 1'h0;
  logic stall = 1'h0;
  logic park_self, dyn_prefetch_off, predict_off, retain_held, discard_pulse;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] ctrl_m = 32'h0000_0020;
  rpb_dec_s exp_q[$];
  bit pend = 0;
  rpb_req_s pend_r;
  rpb_dec_s pend_d;
  logic [31:0] a;

  always #4 ref_clk = ~ref_clk;

  rpb_top #(.DISC_LONG_CYC(LONG_C), .DISC_SHORT_CYC(SHORT_C), .BUF_DEPTH(2)) i_rpb_top (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .dec_valid(dec_valid), .dec(dec), .dec_ready(dec_ready),
    .pcix_mode(pcix_mode), .mto_short(mto_short), .term_valid(term_valid),
    .term_by_bridge(term_by_bridge), .park_self(park_self), .dyn_prefetch_off(dyn_prefetch_off),
    .predict_off(predict_off), .retain_held(retain_held), .discard_pulse(discard_pulse));

  rpb_pci_master i_rpb_pci_master (
    .ref_clk(ref_clk), .resetn(resetn), .stall(stall), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .dec_valid(dec_valid), .dec_ready(dec_ready));

  // ---------------------------------------------------------------
  // Compare and report
  // ---------------------------------------------------------------
  task automatic chk_val(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  // Retry words are checked on the action alone
  task automatic chk_dec(input rpb_dec_s e, input rpb_dec_s g);
    chk_val("dec.act", 32'(e.act), 32'(g.act));
    if (e.act != ACT_RETRY)
    begin
      chk_val("dec.depth", 32'(e.depth), 32'(g.depth));
      chk_val("dec.keep", 32'(e.keep), 32'(g.keep));
      chk_val("dec.limit_en", 32'(e.limit_en), 32'(g.limit_en));
      if (e.limit_en)
        chk_val("dec.max_bytes", 32'(e.max_bytes), 32'(g.max_bytes));
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge ref_clk)
    if (dec_valid === 1'h1 && dec_ready === 1'h1)
    begin
      if (exp_q.size() == 0)
        chk_val("dec surplus", 32'h0000_0000, 32'h0000_0001);
      else
        chk_dec(exp_q.pop_front(), dec);
    end

  // ---------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------
  function automatic int mbytes(input logic [2:0] c);
    return (c == 1) ? 128 : (c == 2) ? 256 : (c == 4) ? 1024 : (c == 5) ? 2048 : (c == 6) ? 4096 : 512;
  endfunction

  function automatic rpb_dec_s calc(input rpb_req_s r);
    rpb_dec_s d = '0;
    logic [1:0] f;
    f = (r.cmd == RPB_CMD_MRM) ? ctrl_m[5:4] : (r.cmd == RPB_CMD_MRL) ? ctrl_m[7:6] : ctrl_m[9:8];
    d.max_bytes = 13'(mbytes(ctrl_m[14:12]));
    if (!r.pf)
      return d;
    if (r.cmd == RPB_CMD_MR)
      d.depth = (f == 2) ? DEP_FULL : (f == 3) ? DEP_DW1 : DEP_LINE;
    else if (pcix_mode)
      d.depth = DEP_FULL;
    else
    begin
      d.depth = (f == 0) ? DEP_LINE : DEP_FULL;
      d.keep = (f == 1) ? KEEP_DISC : (f == 3) ? KEEP_ANY : KEEP_NONE;
    end
    d.limit_en = (d.depth == DEP_FULL);
    return d;
  endfunction

  // Delayed read: first attempt queues, a matching repeat completes
  task automatic rq(input rpb_cmd_e c, input logic [31:0] ad, input logic [3:0] be, input bit pf, input bit last);
    rpb_req_s r;
    rpb_dec_s d;
    r = '{cmd: c, addr: ad, be: be, pf: pf};
    d = calc(r);
    if (!pend)
    begin
      pend = 1;
      pend_r = r;
      pend_d = d;
    end
    else if (ad != pend_r.addr || be != pend_r.be || (c != pend_r.cmd && !ctrl_m[10]))
      d.act = ACT_RETRY;
    else
    begin
      d = pend_d;
      d.act = ACT_DONE;
      pend = 0;
    end
    exp_q.push_back(d);
    i_rpb_pci_master.send(r, last);
  endtask

  task automatic drain();
    int n = 0;
    while (exp_q.size() != 0 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk_val("queue left", 0, exp_q.size());
  endtask

  task automatic qd(input rpb_cmd_e c);
    rq(c, 32'h3000_0100, 4'hF, 1, 0);
    rq(c, 32'h3000_0100, 4'hF, 1, 1);
    drain();
  endtask

  // ---------------------------------------------------------------
  // Register bus and termination
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    reg_wdata <= ~d;
    if (ad == OFS_CTRL)
      ctrl_m = d & 32'h0000_77F7;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string what);
    reg_addr <= ad;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(posedge ref_clk);
    chk_val(what, e, reg_rdata);
  endtask

  task automatic term_chk(input bit byb, input bit held, input int lim);
    int n = 1;
    term_valid <= 1'h1;
    term_by_bridge <= byb;
    @(posedge ref_clk);
    term_valid <= 1'h0;
    @(posedge ref_clk);
    chk_val("retain_held", 32'(held), 32'(retain_held));
    if (held)
    begin
      while (discard_pulse !== 1'h1 && n < 100)
      begin
        @(posedge ref_clk);
        n++;
      end
      chk_val("discard delay", lim + 2, n);
      @(posedge ref_clk);
      chk_val("retain after discard", 0, 32'(retain_held));
    end
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(51));
    repeat (6) @(posedge ref_clk);
    resetn <= 1'h1;
    @(posedge ref_clk);
    chk_val("flags", 7'h02, {park_self, dyn_prefetch_off, predict_off, retain_held, discard_pulse, req_ready, dec_valid});
    rd(OFS_STAT, 32'h0000_0001, "stat reset");
    rd(OFS_CTRL, 32'h0000_0020, "ctrl reset");
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80, 32'h0000_0000, "unmapped");
    rd(OFS_CTRL, 32'h0000_0020, "ctrl kept");
    wr(OFS_CTRL, 32'hFFFF_FFFF);
    rd(OFS_CTRL, 32'h0000_77F7, "ctrl ones");
    chk_val("ctrl copies", 3'h7, {park_self, dyn_prefetch_off, predict_off});
    wr(OFS_CTRL, 32'h0000_0000);
    chk_val("ctrl copies", 3'h0, {park_self, dyn_prefetch_off, predict_off});
    $display("test registers done");
    for (int i = 0; i < 16; i++)
    begin
      pcix_mode <= i[3];
      wr(OFS_CTRL, {17'h0, i[2:0], 2'h0, i[1:0], i[2:1], i[1:0], 1'h0, 3'($urandom)});
      for (int c = 0; c < 3; c++)
      begin
        a = $urandom;
        rq(rpb_cmd_e'(c), a, a[3:0], a[7:5] != 0, 0);
        rq(rpb_cmd_e'(c), a, a[3:0], a[7:5] != 0, c == 2);
      end
      drain();
    end
    pcix_mode <= 1'h0;
    $display("test decisions done");
    wr(OFS_CTRL, 32'h0000_0000);
    rq(RPB_CMD_MR, 32'h1000_0040, 4'hF, 1, 0);
    rq(RPB_CMD_MRL, 32'h1000_0040, 4'hF, 1, 0);
    rq(RPB_CMD_MR, 32'h1000_0080, 4'hF, 1, 0);
    rq(RPB_CMD_MR, 32'h1000_0040, 4'h3, 1, 0);
    rq(RPB_CMD_MR, 32'h1000_0040, 4'hF, 1, 1);
    drain();
    wr(OFS_CTRL, 32'h0000_0400);
    rq(RPB_CMD_MRM, 32'h1000_0100, 4'hC, 1, 0);
    rq(RPB_CMD_MR, 32'h1000_0100, 4'hC, 1, 1);
    drain();
    $display("test retry done");
    stall <= 1'h1;
    rq(RPB_CMD_MR, 32'h2000_0000, 4'hF, 1, 0);
    rq(RPB_CMD_MR, 32'h2000_0000, 4'hF, 1, 1);
    repeat (3) @(posedge ref_clk);
    chk_val("req_ready full", 0, 32'(req_ready));
    stall <= 1'h0;
    drain();
    $display("test buffer done");
    wr(OFS_CTRL, 32'h0000_0010);
    rq(RPB_CMD_MRM, 32'h3000_0000, 4'hF, 1, 1);
    wr(OFS_CTRL, 32'h0000_0030);
    rq(RPB_CMD_MRM, 32'h3000_0000, 4'hF, 1, 1);
    drain();
    term_chk(0, 0, 0);
    mto_short <= 1'h1;
    wr(OFS_CTRL, 32'h0000_0010);
    qd(RPB_CMD_MRM);
    term_chk(1, 1, SHORT_C);
    rd(OFS_STAT, 32'h0000_0011, "stat short hold");
    mto_short <= 1'h0;
    wr(OFS_CTRL, 32'h0000_00C0);
    qd(RPB_CMD_MRL);
    term_chk(0, 1, LONG_C);
    $display("test retention done");
    tally_and_finish();
  end

  // Whole run is a few hundred cycles; this is 50000, over a hundred times that
  initial
  begin
    #400000;
    err_count++;
    tally_and_finish();
  end
endmodule
